// ==== rtl/clock_select_defines.vh ====
// Offsets, field positions, reset values and write masks of control registers 0 to 3
`ifndef CLOCK_SELECT_DEFINES_VH
`define CLOCK_SELECT_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_FREE_RUN_BYPASS_CONTROL   8'h00
`define OFS_INPUT_PRIORITY_CONTROL    8'h01
`define OFS_LOOP_BANDWIDTH_CONTROL    8'h02
`define OFS_INPUT_SELECT_HOLD_CONTROL 8'h03

// ----------------------------------------------------------------
// Reset values and writable-bit masks
// ----------------------------------------------------------------
`define RST_FREE_RUN_BYPASS_CONTROL   8'h14
`define RST_INPUT_PRIORITY_CONTROL    8'hE4
`define RST_LOOP_BANDWIDTH_CONTROL    8'h42
`define RST_INPUT_SELECT_HOLD_CONTROL 8'h05
`define WMASK_FREE_RUN_BYPASS_CONTROL   8'h62
`define WMASK_INPUT_PRIORITY_CONTROL    8'h0F
`define WMASK_LOOP_BANDWIDTH_CONTROL    8'hF0
`define WMASK_INPUT_SELECT_HOLD_CONTROL 8'hF0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_FREE_RUN              6
`define BIT_OUTPUTS_UNSQUELCHED   5
`define BIT_PLL_BYPASS            1
`define MSB_SECOND_PRIORITY       3
`define LSB_SECOND_PRIORITY       2
`define MSB_FIRST_PRIORITY        1
`define LSB_FIRST_PRIORITY        0
`define MSB_LOOP_BANDWIDTH        7
`define LSB_LOOP_BANDWIDTH        4
`define MSB_REGISTER_INPUT_SELECT 7
`define LSB_REGISTER_INPUT_SELECT 6
`define BIT_FORCED_HOLD           5
`define BIT_CALIBRATION_SQUELCH   4

// ----------------------------------------------------------------
// Codes
// ----------------------------------------------------------------
`define INPUT_CODE_FIRST   2'h0
`define INPUT_CODE_SECOND  2'h1
`define MODE_MANUAL        2'h0
`define MODE_AUTO_NONREV   2'h1
`define MODE_AUTO_REV      2'h2
`define LOOP_BANDWIDTH_RST 4'h4

`endif

// ==== rtl/clock_select_output_control.v ====
// Control registers 0 to 3: free run, squelch, bypass, priorities, bandwidth, selection
`timescale 1ns/100ps
`include "clock_select_defines.vh"

module clock_select_output_control (
	input  wire       mclk,                    // System clock, 20 MHz
	input  wire       resetn,                  // Async reset, active low
	input  wire [7:0] reg_addr,                // Register address from serial port
	input  wire [7:0] reg_wr_data,             // Write data
	input  wire       reg_wr,                  // Write strobe, one cycle
	input  wire       reg_rd,                  // Read strobe, one cycle
	output reg  [7:0] reg_rd_data,             // Read data, valid cycle after strobe
	input  wire [1:0] selection_mode_field,    // Selection method from mode register
	input  wire       pin_select_enable,       // Pin-controlled selection enabled
	input  wire       external_select_pin,     // Asynchronous select pin
	input  wire       auto_selected_input,     // Choice of automatic selector, 1 = second
	input  wire       calibration_start,       // Calibration starts, one-cycle pulse
	input  wire       calibration_running,     // Calibration in progress, level
	input  wire       calibration_done,        // Calibration completed successfully
	output reg        route_crystal_to_second, // Crystal drives second input path
	output reg        pll_bypass,              // Selected input goes straight to outputs
	output reg        clock_output_enable,     // Output buffers driven (not squelched)
	output reg  [1:0] first_priority_field,    // Input ranked first
	output reg  [1:0] second_priority_field,   // Input ranked second
	output reg        priority_valid,          // Both priority codes are defined
	output reg  [3:0] loop_bandwidth_code,     // Bandwidth code in effect
	output reg        active_input,            // Active input, 0 first, 1 second
	output reg        digital_hold,            // Device held in digital hold
	output reg        auto_selection,          // Automatic selection engaged
	output reg        auto_revertive           // Automatic selection reverts
);

	// ----------------------------------------------------------------
	// Integration notes
	// ----------------------------------------------------------------
	// Bypass is not cross-checked against hold, calibration or output
	// format; software keeps it to hold or pre-calibration use only.
	// Reserved mode and select codes hold the last active input, so a
	// stray write never swaps the reference under a locked loop.
	// Reserved priority codes pass through raw; priority_valid drops so
	// the automatic selector can ignore them.
	// The select pin costs about five cycles through its filter, a
	// trade of latency for immunity to slow or bouncing edges.
	// Bandwidth writes are staged and only reach the loop when a
	// calibration starts, so the loop never retunes while locked.
	// Output enable is low in reset and rises one edge after release,
	// once the register bits have been decoded.
	// Read data are registered and hold until the next read strobe.

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	wire [7:0] free_run_bypass_control;
	wire [7:0] input_priority_control;
	wire [7:0] loop_bandwidth_control;
	wire [7:0] input_select_hold_control;
	wire       pin_level;

	// One strobe per register; unmapped offsets match none of them
	wire       wr_free_run    = reg_wr && (reg_addr == `OFS_FREE_RUN_BYPASS_CONTROL);
	wire       wr_priority    = reg_wr && (reg_addr == `OFS_INPUT_PRIORITY_CONTROL);
	wire       wr_bandwidth   = reg_wr && (reg_addr == `OFS_LOOP_BANDWIDTH_CONTROL);
	wire       wr_select_hold = reg_wr && (reg_addr == `OFS_INPUT_SELECT_HOLD_CONTROL);

	control_register #(
		.RESET_VALUE (`RST_FREE_RUN_BYPASS_CONTROL),
		.WRITE_MASK  (`WMASK_FREE_RUN_BYPASS_CONTROL)
	) u_reg0 (
		.mclk    (mclk),
		.resetn  (resetn),
		.wr_en   (wr_free_run),
		.wr_data (reg_wr_data),
		.value   (free_run_bypass_control)
	);

	control_register #(
		.RESET_VALUE (`RST_INPUT_PRIORITY_CONTROL),
		.WRITE_MASK  (`WMASK_INPUT_PRIORITY_CONTROL)
	) u_reg1 (
		.mclk    (mclk),
		.resetn  (resetn),
		.wr_en   (wr_priority),
		.wr_data (reg_wr_data),
		.value   (input_priority_control)
	);

	control_register #(
		.RESET_VALUE (`RST_LOOP_BANDWIDTH_CONTROL),
		.WRITE_MASK  (`WMASK_LOOP_BANDWIDTH_CONTROL)
	) u_reg2 (
		.mclk    (mclk),
		.resetn  (resetn),
		.wr_en   (wr_bandwidth),
		.wr_data (reg_wr_data),
		.value   (loop_bandwidth_control)
	);

	control_register #(
		.RESET_VALUE (`RST_INPUT_SELECT_HOLD_CONTROL),
		.WRITE_MASK  (`WMASK_INPUT_SELECT_HOLD_CONTROL)
	) u_reg3 (
		.mclk    (mclk),
		.resetn  (resetn),
		.wr_en   (wr_select_hold),
		.wr_data (reg_wr_data),
		.value   (input_select_hold_control)
	);

	// Select pin arrives from the board, so it is filtered first
	pin_synchronizer u_pin_sync (
		.mclk      (mclk),
		.resetn    (resetn),
		.pin_in    (external_select_pin),
		.level_out (pin_level)
	);

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	reg [7:0] next_rd_data;

	// Unmapped offsets read as zero
	always @* begin
		case (reg_addr)
			`OFS_FREE_RUN_BYPASS_CONTROL:   next_rd_data = free_run_bypass_control;
			`OFS_INPUT_PRIORITY_CONTROL:    next_rd_data = input_priority_control;
			`OFS_LOOP_BANDWIDTH_CONTROL:    next_rd_data = loop_bandwidth_control;
			`OFS_INPUT_SELECT_HOLD_CONTROL: next_rd_data = input_select_hold_control;
			default:                        next_rd_data = 8'h00;
		endcase
	end

	// Data held until the next read strobe
	// A read in the cycle of a write returns the old contents
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			reg_rd_data <= 8'h00;
		end else if (reg_rd) begin
			reg_rd_data <= next_rd_data;
		end
	end

	// ----------------------------------------------------------------
	// Field decode
	// ----------------------------------------------------------------
	// Single-bit controls of register 0
	wire       free_run_bit     = free_run_bypass_control[`BIT_FREE_RUN];
	wire       unsquelched_bit  = free_run_bypass_control[`BIT_OUTPUTS_UNSQUELCHED];
	wire       bypass_bit       = free_run_bypass_control[`BIT_PLL_BYPASS];
	// Two-bit codes and the staged bandwidth
	wire [1:0] first_code       =
		input_priority_control[`MSB_FIRST_PRIORITY:`LSB_FIRST_PRIORITY];
	wire [1:0] second_code      =
		input_priority_control[`MSB_SECOND_PRIORITY:`LSB_SECOND_PRIORITY];
	wire [3:0] bandwidth_staged =
		loop_bandwidth_control[`MSB_LOOP_BANDWIDTH:`LSB_LOOP_BANDWIDTH];
	wire [1:0] register_input_select =
		input_select_hold_control[`MSB_REGISTER_INPUT_SELECT:`LSB_REGISTER_INPUT_SELECT];
	// Single-bit controls of register 3
	wire       forced_hold_bit     = input_select_hold_control[`BIT_FORCED_HOLD];
	wire       calibration_squelch = input_select_hold_control[`BIT_CALIBRATION_SQUELCH];

	// ----------------------------------------------------------------
	// Input selection
	// ----------------------------------------------------------------
	reg next_active_input;
	reg next_auto_selection;
	reg next_auto_revertive;

	// Reserved codes keep the current choice rather than guess an input
	always @* begin
		next_active_input   = active_input;
		next_auto_selection = auto_selection;
		next_auto_revertive = auto_revertive;
		case (selection_mode_field)
			`MODE_MANUAL: begin
				next_auto_selection = 1'b0;
				next_auto_revertive = 1'b0;
				// Pin control outranks the register field
				if (pin_select_enable)
					next_active_input = pin_level;
				else if (register_input_select == `INPUT_CODE_FIRST)
					next_active_input = 1'b0;
				else if (register_input_select == `INPUT_CODE_SECOND)
					next_active_input = 1'b1;
			end
			// Both automatic modes pass the selector's choice through
			`MODE_AUTO_NONREV: begin
				next_auto_selection = 1'b1;
				next_auto_revertive = 1'b0;
				next_active_input   = auto_selected_input;
			end
			`MODE_AUTO_REV: begin
				next_auto_selection = 1'b1;
				next_auto_revertive = 1'b1;
				next_active_input   = auto_selected_input;
			end
			// Reserved mode keeps every flag as it stands
			default: begin
				next_active_input = active_input;
			end
		endcase
		// Hold freezes the choice made before it was forced
		if (forced_hold_bit)
			next_active_input = active_input;
	end

	// ----------------------------------------------------------------
	// Output control state
	// ----------------------------------------------------------------
	// Squelch only while calibration runs or has not yet succeeded
	wire squelch_now = calibration_squelch &&
		(calibration_running || !calibration_done);

	// Free-run routing and bypass follow their bits one edge late
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			route_crystal_to_second <= 1'b0;
			pll_bypass              <= 1'b0;
		end else begin
			route_crystal_to_second <= free_run_bit;
			// Bypass is honoured as written; its safe use is software's duty
			pll_bypass              <= bypass_bit;
		end
	end

	// Outputs start squelched so nothing leaves before the bits are decoded
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			clock_output_enable <= 1'b0;
		end else begin
			clock_output_enable <= unsquelched_bit || !squelch_now;
		end
	end

	// ----------------------------------------------------------------
	// Priority ranking
	// ----------------------------------------------------------------
	// Codes are passed raw; the flag tells the selector to distrust them
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			first_priority_field  <= `INPUT_CODE_FIRST;
			second_priority_field <= `INPUT_CODE_SECOND;
			priority_valid        <= 1'b1;
		end else begin
			first_priority_field  <= first_code;
			second_priority_field <= second_code;
			priority_valid        <= !first_code[1] && !second_code[1];
		end
	end

	// ----------------------------------------------------------------
	// Loop bandwidth
	// ----------------------------------------------------------------
	// Staged code waits for calibration so the loop never changes mid-lock
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			loop_bandwidth_code <= `LOOP_BANDWIDTH_RST;
		end else if (calibration_start) begin
			loop_bandwidth_code <= bandwidth_staged;
		end
	end

	// ----------------------------------------------------------------
	// Selection and hold state
	// ----------------------------------------------------------------
	// Active input only moves when the selection logic asks for it
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			active_input <= 1'b0;
		end else begin
			active_input <= next_active_input;
		end
	end

	// Hold and the auto selection flag share an edge so they never overlap; auto_revertive is not gated by hold
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			digital_hold   <= 1'b0;
			auto_selection <= 1'b0;
			auto_revertive <= 1'b0;
		end else begin
			digital_hold   <= forced_hold_bit;
			auto_selection <= next_auto_selection && !forced_hold_bit;
			auto_revertive <= next_auto_revertive;
		end
	end

endmodule

// ==== rtl/control_register.v ====
// One 8-bit control register with per-bit write mask and fixed reset value
`timescale 1ns/100ps

module control_register #(
	parameter [7:0] RESET_VALUE = 8'h00,
	parameter [7:0] WRITE_MASK  = 8'h00
) (
	input  wire       mclk,     // System clock
	input  wire       resetn,   // Async reset, active low
	input  wire       wr_en,    // Write strobe for this register
	input  wire [7:0] wr_data,  // Write data
	output reg  [7:0] value     // Stored value
);

	// ----------------------------------------------------------------
	// Masked storage
	// ----------------------------------------------------------------
	// Reserved bits keep their reset value for ever
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			value <= RESET_VALUE;
		end else if (wr_en) begin
			value <= (wr_data & WRITE_MASK) | (RESET_VALUE & ~WRITE_MASK);
		end
	end

endmodule

// ==== rtl/pin_synchronizer.v ====
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps

module pin_synchronizer (
	input  wire mclk,      // System clock
	input  wire resetn,    // Async reset, active low
	input  wire pin_in,    // Asynchronous pin level
	output reg  level_out  // Filtered, synchronous level
);

	reg stage1;
	reg stage2;
	reg stage3;

	// ----------------------------------------------------------------
	// Chain and agreement filter
	// ----------------------------------------------------------------
	// Stage one feeds stage two only; metastability stays in the chain
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			stage1    <= 1'b0;
			stage2    <= 1'b0;
			stage3    <= 1'b0;
			level_out <= 1'b0;
		end else begin
			stage1 <= pin_in;
			stage2 <= stage1;
			stage3 <= stage2;
			if (stage2 == stage3)
				level_out <= stage3;
		end
	end

endmodule

// ==== sim/clock_select_output_control_monitor.sv ====
// Port-level assertions for the clock select and output control block
`timescale 1ns/100ps
module clock_select_output_control_monitor (
	input wire       mclk,                    // Clock
	input wire       resetn,                  // Reset, low
	input wire [7:0] reg_addr,                // Address
	input wire [7:0] reg_wr_data,             // Write data
	input wire       reg_wr,                  // Write strobe
	input wire       reg_rd,                  // Read strobe
	input wire [7:0] reg_rd_data,             // Read data
	input wire [1:0] selection_mode_field,    // Mode
	input wire       calibration_start,       // Cal start
	input wire       calibration_running,     // Cal busy
	input wire       calibration_done,        // Cal ok
	input wire       route_crystal_to_second, // Free run
	input wire       pll_bypass,              // Bypass
	input wire       clock_output_enable,     // Unsquelched
	input wire [1:0] first_priority_field,    // First rank
	input wire [1:0] second_priority_field,   // Second rank
	input wire       priority_valid,          // Codes defined
	input wire [3:0] loop_bandwidth_code,     // Bandwidth
	input wire       digital_hold,            // Hold
	input wire       auto_selection,          // Auto
	input wire       auto_revertive           // Revert
);
// ----------------------------------------
// Properties
// ----------------------------------------
default clocking @(posedge mclk); endclocking
default disable iff (!resetn);
// Decoded outputs lag the register by one edge, so two edges after the write
chk_route_bypass_follow: assert property (
	reg_wr && reg_addr == 8'h00 |-> ##2 {route_crystal_to_second, pll_bypass}
	== {$past(reg_wr_data[6], 2), $past(reg_wr_data[1], 2)}) else $error("bypass or route wrong");
chk_priority_follow: assert property (
	reg_wr && reg_addr == 8'h01 |-> ##2 {second_priority_field, first_priority_field}
	== $past(reg_wr_data[3:0], 2)) else $error("priority fields wrong");
chk_priority_valid_flag: assert property (
	priority_valid == (!first_priority_field[1] && !second_priority_field[1]))
	else $error("priority valid wrong");
chk_hold_follow: assert property (
	reg_wr && reg_addr == 8'h03 |-> ##2 digital_hold == $past(reg_wr_data[5], 2))
	else $error("hold wrong");
chk_hold_no_auto: assert property (
	digital_hold |-> !auto_selection) else $error("auto during hold");
chk_bandwidth_waits_cal: assert property (
	!calibration_start |=> $stable(loop_bandwidth_code)) else $error("bandwidth moved");
chk_unmapped_read_zero: assert property (
	reg_rd && reg_addr > 8'h03 |=> reg_rd_data == 8'h00) else $error("unmapped read");
chk_read_data_holds: assert property (
	!reg_rd |=> $stable(reg_rd_data)) else $error("read data moved");
chk_revertive_mode: assert property (
	$past(resetn) && $past(selection_mode_field) != 2'h3
	|-> auto_revertive == ($past(selection_mode_field) == 2'h2))
	else $error("revertive wrong");
chk_enable_after_cal: assert property (
	$past(resetn) && $past(calibration_done) && !$past(calibration_running)
	|-> clock_output_enable) else $error("output squelched");
cover property (reg_wr && reg_addr == 8'h03 && reg_wr_data[5]);
cover property (calibration_start);
cover property (reg_rd && reg_addr > 8'h03);
endmodule
bind clock_select_output_control clock_select_output_control_monitor mon_u (
	.mclk                    (mclk),
	.resetn                  (resetn),
	.reg_addr                (reg_addr),
	.reg_wr_data             (reg_wr_data),
	.reg_wr                  (reg_wr),
	.reg_rd                  (reg_rd),
	.reg_rd_data             (reg_rd_data),
	.selection_mode_field    (selection_mode_field),
	.calibration_start       (calibration_start),
	.calibration_running     (calibration_running),
	.calibration_done        (calibration_done),
	.route_crystal_to_second (route_crystal_to_second),
	.pll_bypass              (pll_bypass),
	.clock_output_enable     (clock_output_enable),
	.first_priority_field    (first_priority_field),
	.second_priority_field   (second_priority_field),
	.priority_valid          (priority_valid),
	.loop_bandwidth_code     (loop_bandwidth_code),
	.digital_hold            (digital_hold),
	.auto_selection          (auto_selection),
	.auto_revertive          (auto_revertive)
);

// ==== sim/clock_select_output_control_test.sv ====
// Self-checking bench for the clock select and output control block
`timescale 1ns/100ps
module clock_select_output_control_test;
// ----------------------------------------
// Signals and register model
// ----------------------------------------
reg         mclk, resetn, reg_wr, reg_rd, pin_select_enable, external_select_pin;
reg         auto_selected_input, calibration_start, calibration_running, calibration_done;
reg  [7:0]  reg_addr, reg_wr_data;
reg  [1:0]  selection_mode_field;
wire [7:0]  reg_rd_data;
wire [1:0]  first_priority_field, second_priority_field;
wire [3:0]  loop_bandwidth_code;
wire        route_crystal_to_second, pll_bypass, clock_output_enable, priority_valid;
wire        active_input, digital_hold, auto_selection, auto_revertive;
reg  [7:0]  m [0:3];  // Expected register contents
reg  [7:0]  wm [0:3]; // Writable bits
reg  [15:0] s;        // Random state
integer     n_fail, num_checks, i;
clock_select_output_control dut_u (
	.mclk                    (mclk),
	.resetn                  (resetn),
	.reg_addr                (reg_addr),
	.reg_wr_data             (reg_wr_data),
	.reg_wr                  (reg_wr),
	.reg_rd                  (reg_rd),
	.reg_rd_data             (reg_rd_data),
	.selection_mode_field    (selection_mode_field),
	.pin_select_enable       (pin_select_enable),
	.external_select_pin     (external_select_pin),
	.auto_selected_input     (auto_selected_input),
	.calibration_start       (calibration_start),
	.calibration_running     (calibration_running),
	.calibration_done        (calibration_done),
	.route_crystal_to_second (route_crystal_to_second),
	.pll_bypass              (pll_bypass),
	.clock_output_enable     (clock_output_enable),
	.first_priority_field    (first_priority_field),
	.second_priority_field   (second_priority_field),
	.priority_valid          (priority_valid),
	.loop_bandwidth_code     (loop_bandwidth_code),
	.active_input            (active_input),
	.digital_hold            (digital_hold),
	.auto_selection          (auto_selection),
	.auto_revertive          (auto_revertive)
);
initial begin
	mclk = 1'h0;
	forever #25 mclk = ~mclk;
end
function [15:0] nx(input [15:0] v);
	nx = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
endfunction
task chk(input [15:0] got, input [15:0] exp);
	num_checks = num_checks + 1;
	if (got !== exp) begin
		n_fail = n_fail + 1;
		$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
	end
endtask
// Reserved bits are masked in the model, never in the design's favour
task wr(input [7:0] a, input [7:0] d);
	reg_addr = a;
	reg_wr_data = d;
	reg_wr = 1'h1;
	@(negedge mclk);
	reg_wr = 1'h0;
	if (a < 8'h04) m[a[1:0]] = (m[a[1:0]] & ~wm[a[1:0]]) | (d & wm[a[1:0]]);
	// Idle cycle so a following strobe never rises in the step it fell
	@(negedge mclk);
endtask
task rd(input [7:0] a);
	reg_addr = a;
	reg_rd = 1'h1;
	@(negedge mclk);
	reg_rd = 1'h0;
	chk(reg_rd_data, (a < 8'h04) ? m[a[1:0]] : 8'h00);
	@(negedge mclk);
endtask
task outs;
	reg squelch;
	begin
		squelch = m[3][4] & (calibration_running | !calibration_done);
		chk({route_crystal_to_second, pll_bypass}, {m[0][6], m[0][1]});
		chk(digital_hold, m[3][5]);
		chk({first_priority_field, second_priority_field}, {m[1][1:0], m[1][3:2]});
		chk(priority_valid, !m[1][1] && !m[1][3]);
		chk(clock_output_enable, m[0][5] | !squelch);
	end
endtask
// Pin path needs several cycles through its filter, hence the wait count
task sel(input [7:0] d, input e, input integer w);
	wr(8'h03, d);
	repeat (w) @(negedge mclk);
	chk(active_input, e);
endtask
task close_out;
	$display("checks %0d mismatches %0d", num_checks, n_fail);
	if (n_fail == 0 && num_checks > 0)
		$display("STATUS OK");
	else
		$display("STATUS NOT OK");
	$finish;
endtask
// ----------------------------------------
// Watchdog and main sequence
// ----------------------------------------
initial begin
	#100000;
	n_fail = n_fail + 1;
	close_out;
end
initial begin
	{reg_wr, reg_rd, pin_select_enable, external_select_pin, auto_selected_input} = 5'h00;
	{calibration_start, calibration_running, calibration_done, selection_mode_field} = 5'h00;
	reg_addr = 8'h00;
	reg_wr_data = 8'h00;
	resetn = 1'h0;
	n_fail = 0;
	num_checks = 0;
	s = 16'hA49B;
	m[0] = 8'h14; m[1] = 8'hE4; m[2] = 8'h42; m[3] = 8'h05;
	wm[0] = 8'h62; wm[1] = 8'h0F; wm[2] = 8'hF0; wm[3] = 8'hF0;
	repeat (6) @(negedge mclk);
	resetn = 1'h1;
	@(negedge mclk);
	outs;
	chk(loop_bandwidth_code, 4'h4);
	for (i = 0; i < 5; i = i + 1) rd(i[7:0]);
	$display("reset test done");
	// Random bypass bits land before any calibration has run
	// No output format port exists here, so bypass never meets CMOS
	for (i = 0; i < 24; i = i + 1) begin
		s = nx(s);
		wr({5'h00, s[10:8]}, s[7:0]);
		rd({5'h00, s[10:8]});
		outs;
	end
	$display("random register test done");
	wr(8'h00, 8'h00);
	wr(8'h02, 8'hA5);
	@(negedge mclk);
	chk(loop_bandwidth_code, 4'h4);
	calibration_start = 1'h1;
	@(negedge mclk);
	calibration_start = 1'h0;
	chk(loop_bandwidth_code, 4'hA);
	$display("bandwidth test done");
	wr(8'h03, 8'h10);
	for (i = 0; i < 4; i = i + 1) begin
		calibration_running = i[1];
		calibration_done = i[1];
		wr(8'h00, {2'h0, i[0], 5'h00});
		@(negedge mclk);
		outs;
	end
	calibration_running = 1'h0;
	$display("squelch test done");
	sel(8'h40, 1'h1, 1);
	sel(8'hC0, 1'h1, 1);
	sel(8'h00, 1'h0, 1);
	pin_select_enable = 1'h1;
	external_select_pin = 1'h1;
	sel(8'h00, 1'h1, 8);
	external_select_pin = 1'h0;
	sel(8'h40, 1'h0, 8);
	pin_select_enable = 1'h0;
	sel(8'h00, 1'h0, 2);
	// Mode 3 is reserved: the last choice must survive a flip of the selector
	for (i = 0; i < 4; i = i + 1) begin
		selection_mode_field = i[1:0];
		auto_selected_input = (i != 3);
		repeat (3) @(negedge mclk);
		chk({auto_selection, auto_revertive, active_input}, {i != 0, i[1], i != 0});
	end
	// Active input stays on the second input once hold has landed, even when the selector flips
	selection_mode_field = 2'h2;
	auto_selected_input = 1'h1;
	sel(8'h20, 1'h1, 3);
	chk(auto_selection, 1'h0);
	auto_selected_input = 1'h0;
	repeat (3) @(negedge mclk);
	chk(active_input, 1'h1);
	$display("selection test done");
	close_out;
end
endmodule
